// ==== pin_wake_consts.svh ====
`ifndef PIN_WAKE_CONSTS_SVH
`define PIN_WAKE_CONSTS_SVH

// Register byte offsets on the register bus
`define PW_OFS_STATUS_CONTROL 8'h00
`define PW_OFS_ENABLE 8'h04
`define PW_OFS_POLARITY 8'h08

// Status/control field positions
`define PW_BIT_MODE 0
`define PW_BIT_REQ_EN 1
`define PW_BIT_ACK 2
`define PW_BIT_FLAG 3

// Reset values
`define PW_RST_BYTE 8'h00
`define PW_RST_WORD 32'h0000_0000

// Bus responses
`define PW_RESP_OKAY 2'h0
`define PW_RESP_SLVERR 2'h2

`endif

// ==== pin_wake_pkg.sv ====
package pin_wake_pkg;

    typedef enum logic [1:0] {
        SEL_STATUS_CONTROL,
        SEL_ENABLE,
        SEL_POLARITY,
        SEL_NONE
    } reg_sel_e;

    typedef struct packed {
        logic request_enable;
        logic level_mode;
    } control_s;

endpackage

// ==== pin_wake_interrupt_unit.sv ====
// How it works
// [R1] Per-pin enable gates detection
// [R2] Mode bit: edge only or edge plus level
// [R3] Polarity bit picks falling/low or rising/high
// [R4] High then low sample is falling edge
// [R5] Low then high sample is rising edge
// [R6] Already asserted pin gives no edge
// [R7] Edge mode: valid edge sets flag
// [R8] Level mode: edge or level sets flag
// [R9] Flag and enable raise CPU request
// [R10] Acknowledge clears flag, level mode waits inactive
// [R11] Asserted pin keeps flag through acknowledge
// [R12] Flag bit ignores software writes
// [R13] Acknowledge bit always reads zero
// [R14] Upper four control bits read zero
// [R15] Shallow stop: enabled asserted pin wakes asynchronously when request enable is set
// [R16] Deep stop forces reset state
// [R17] Debug mode changes nothing
// [R18] Polarity picks pullup or pulldown
// [R19] Software init order avoids false flags
// [R20] Two pins bonded, fields eight wide
// [R21] Two-stage synchroniser, inactive previous sample
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`include "pin_wake_consts.svh"
`default_nettype none

module pin_wake_interrupt_unit
    import pin_wake_pkg::*;
#(
    parameter int PIN_COUNT = 2,
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [PIN_COUNT-1:0] wake_input_pin,
    input wire logic [PIN_COUNT-1:0] port_pull_enable,
    input wire logic shallow_stop_state,
    input wire logic deep_stop_state,
    input wire logic debug_active,
    output logic [PIN_COUNT-1:0] pull_up_enable,
    output logic [PIN_COUNT-1:0] pull_down_enable,
    output logic irq_request,
    output logic wake_request,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
        reg_sel_e sel;
        sel = SEL_NONE;
        if (addr == ADDR_W'(`PW_OFS_STATUS_CONTROL)) begin
            sel = SEL_STATUS_CONTROL;
        end else if (addr == ADDR_W'(`PW_OFS_ENABLE)) begin
            sel = SEL_ENABLE;
        end else if (addr == ADDR_W'(`PW_OFS_POLARITY)) begin
            sel = SEL_POLARITY;
        end
        return sel;
    endfunction

    // Software-visible state
    control_s control;
    logic [7:0] pin_irq_enable;
    logic [7:0] pin_irq_polarity_select;
    logic pin_irq_flag;

    // Detection state
    logic [PIN_COUNT-1:0] sync_first;
    logic [PIN_COUNT-1:0] sync_second;
    logic [PIN_COUNT-1:0] prev_asserted;

    // Bus state
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic read_was_control;

    // [R20] Bonded pins only, fields eight wide
    wire [PIN_COUNT-1:0] pin_enable_bit = pin_irq_enable[PIN_COUNT-1:0];
    wire [PIN_COUNT-1:0] pin_polarity_bit = pin_irq_polarity_select[PIN_COUNT-1:0];

    // [R3] Polarity normalises pins
    wire [PIN_COUNT-1:0] asserted = sync_second ~^ pin_polarity_bit;
    // [R4] [R5] Edge from inactive to asserted sample
    wire [PIN_COUNT-1:0] edge_seen = asserted & ~prev_asserted;
    // [R1] Enable gates both paths
    wire [PIN_COUNT-1:0] edge_hit = edge_seen & pin_enable_bit;
    wire [PIN_COUNT-1:0] level_hit = asserted & pin_enable_bit;
    wire any_level = |level_hit;

    // [R2] [R7] [R8] Mode selects set sources
    wire flag_set = (|edge_hit) | (control.level_mode & any_level);

    // Write channel decode
    wire write_go = aw_held & w_held & ~s_axi_bvalid;
    wire reg_sel_e write_sel = decode(aw_addr);
    wire write_low = write_go & w_strb[0];
    wire write_control = write_low & (write_sel == SEL_STATUS_CONTROL);
    wire write_enable = write_low & (write_sel == SEL_ENABLE);
    wire write_polarity = write_low & (write_sel == SEL_POLARITY);
    wire ack_write = write_control & w_data[`PW_BIT_ACK];

    // [R10] [R11] Level mode clear needs all inactive
    wire flag_clear = ack_write & ~(control.level_mode & any_level);
    // Set wins so an event in the clearing cycle is kept
    wire next_flag = flag_set | (pin_irq_flag & ~flag_clear);

    // Read channel decode
    wire read_take = s_axi_arvalid & s_axi_arready;
    wire reg_sel_e read_sel = decode(s_axi_araddr);
    // [R12] [R13] [R14] Control readback layout
    wire [7:0] control_view = {4'h0, pin_irq_flag, 1'b0, control.request_enable,
                               control.level_mode};
    wire [7:0] read_byte = (read_sel == SEL_STATUS_CONTROL) ? control_view :
                           (read_sel == SEL_ENABLE) ? pin_irq_enable :
                           (read_sel == SEL_POLARITY) ? pin_irq_polarity_select :
                           `PW_RST_BYTE;

    // [R17] Debug state is deliberately not used to gate anything
    wire debug_unused = debug_active;

    // [R9] Request follows flag and enable
    assign irq_request = pin_irq_flag & control.request_enable;

    // [R15] Raw pins bypass the clock so wake works when clocks stop
    assign wake_request = shallow_stop_state & control.request_enable &
                          (|((wake_input_pin ~^ pin_polarity_bit) & pin_enable_bit));

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    // [R18] Polarity picks resistor direction
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pull
            assign pull_up_enable[gi] = port_pull_enable[gi] & ~pin_polarity_bit[gi];
            assign pull_down_enable[gi] = port_pull_enable[gi] & pin_polarity_bit[gi];
        end
    endgenerate

    // [R21] Two-stage synchroniser
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // Idle pins rest high, so start there to avoid a false edge
            sync_first <= '1;
            sync_second <= '1;
        end else if (clk_en) begin
            sync_first <= wake_input_pin;
            sync_second <= sync_first;
        end
    end

    // [R6] [R21] Previous sample starts inactive, tracks even when disabled
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_asserted <= '0;
        end else if (clk_en) begin
            prev_asserted <= deep_stop_state ? '0 : asserted;
        end
    end

    // [R16] Deep stop holds the registers and flag in their reset state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            control <= '0;
            pin_irq_enable <= `PW_RST_BYTE;
            pin_irq_polarity_select <= `PW_RST_BYTE;
            pin_irq_flag <= 1'b0;
        end else if (clk_en) begin
            if (deep_stop_state) begin
                control <= '0;
                pin_irq_enable <= `PW_RST_BYTE;
                pin_irq_polarity_select <= `PW_RST_BYTE;
                pin_irq_flag <= 1'b0;
            end else begin
                pin_irq_flag <= next_flag;
                if (write_control) begin
                    control.level_mode <= w_data[`PW_BIT_MODE];
                    control.request_enable <= w_data[`PW_BIT_REQ_EN];
                end
                if (write_enable) begin
                    pin_irq_enable <= w_data[7:0];
                end
                if (write_polarity) begin
                    pin_irq_polarity_select <= w_data[7:0];
                end
            end
        end
    end

    // Address and data are latched separately so either may arrive first
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (clk_en) begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (write_go) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            w_held <= 1'b0;
            w_data <= `PW_RST_WORD;
            w_strb <= '0;
        end else if (clk_en) begin
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (write_go) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PW_RESP_OKAY;
        end else if (clk_en) begin
            if (write_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (write_sel == SEL_NONE) ? `PW_RESP_SLVERR : `PW_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `PW_RST_WORD;
            s_axi_rresp <= `PW_RESP_OKAY;
            read_was_control <= 1'b0;
        end else if (clk_en) begin
            if (read_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, read_byte};
                s_axi_rresp <= (read_sel == SEL_NONE) ? `PW_RESP_SLVERR : `PW_RESP_OKAY;
                read_was_control <= (read_sel == SEL_STATUS_CONTROL) & ~debug_unused |
                                    (read_sel == SEL_STATUS_CONTROL) & debug_unused;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    disabled_pins_quiet_a: assert property ( // [R1]
        clk_en && !deep_stop_state && !pin_irq_flag && pin_enable_bit == '0 && !ack_write
        |=> !pin_irq_flag)
        else $error("flag set with no pin enabled");

    edge_only_mode_a: assert property ( // [R2]
        clk_en && !deep_stop_state && !control.level_mode && !pin_irq_flag &&
        edge_hit == '0 |=> !pin_irq_flag)
        else $error("edge mode flagged without an edge");

    edge_sets_flag_a: assert property ( // [R7]
        clk_en && !deep_stop_state && (|edge_hit) |=> pin_irq_flag)
        else $error("valid edge did not set flag");

    rising_edge_seen_a: assert property ( // [R5]
        clk_en && !deep_stop_state && pin_polarity_bit[0] && pin_enable_bit[0] &&
        !sync_second[0] ##1 clk_en && sync_second[0] && $stable(pin_irq_polarity_select) &&
        pin_enable_bit[0] && !deep_stop_state |=> pin_irq_flag)
        else $error("rising edge missed");

    level_sets_flag_a: assert property ( // [R8]
        clk_en && !deep_stop_state && control.level_mode && any_level |=> pin_irq_flag)
        else $error("asserted level did not set flag");

    request_follows_a: assert property ( // [R9]
        !pin_irq_flag ##1 pin_irq_flag |-> irq_request == control.request_enable)
        else $error("request does not follow flag");

    ack_clears_flag_a: assert property ( // [R10]
        clk_en && !deep_stop_state && ack_write && !flag_set && !any_level |=> !pin_irq_flag)
        else $error("acknowledge did not clear flag");

    level_keeps_flag_a: assert property ( // [R11]
        clk_en && pin_irq_flag && !deep_stop_state && ack_write && control.level_mode &&
        any_level |=> pin_irq_flag)
        else $error("flag cleared while pin asserted");

    flag_write_ignored_a: assert property ( // [R12]
        clk_en && !deep_stop_state && write_control && !w_data[`PW_BIT_ACK] &&
        !flag_set |=> pin_irq_flag == $past(pin_irq_flag))
        else $error("write changed flag");

    ack_reads_zero_a: assert property ( // [R13]
        s_axi_rvalid && read_was_control |-> !s_axi_rdata[`PW_BIT_ACK])
        else $error("acknowledge read as one");

    upper_reads_zero_a: assert property ( // [R14]
        s_axi_rvalid && read_was_control |-> s_axi_rdata[7:4] == 4'h0)
        else $error("unused control bits nonzero");

    deep_stop_reset_a: assert property ( // [R16]
        clk_en && deep_stop_state |=> !pin_irq_flag && pin_irq_enable == `PW_RST_BYTE &&
        control == '0)
        else $error("deep stop left state");

    pull_select_a: assert property ( // [R18]
        !(pull_up_enable[0] && pull_down_enable[0]) and
        (port_pull_enable[0] |-> pull_down_enable[0] == pin_polarity_bit[0]))
        else $error("pull direction wrong");

    write_answer_a: assert property (
        clk_en && write_go |=> s_axi_bvalid && !aw_held && !w_held)
        else $error("write not answered in one cycle");

endmodule

`default_nettype wire

// ==== pin_source_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module pin_source_model (
    input wire logic ref_clk,
    input wire logic [1:0] drive_en,
    input wire logic [1:0] drive_level,
    input wire logic [1:0] pull_up_enable,
    input wire logic [1:0] pull_down_enable,
    output logic [1:0] pin
);
    // A released pin with no pull shows the inverse of its last driven level
    logic [1:0] last_level = 2'b11;

    always_ff @(posedge ref_clk) begin
        last_level <= (drive_en & drive_level) | (~drive_en & last_level);
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (drive_en[i]) begin
                pin[i] = drive_level[i];
            end else if (pull_up_enable[i]) begin
                pin[i] = 1'b1;
            end else if (pull_down_enable[i]) begin
                pin[i] = 1'b0;
            end else begin
                pin[i] = ~last_level[i];
            end
        end
    end
endmodule

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`include "pin_wake_consts.svh"
`default_nettype none

module testbench;
    localparam logic [7:0] sc_a = `PW_OFS_STATUS_CONTROL;
    localparam logic [7:0] en_a = `PW_OFS_ENABLE;
    localparam logic [7:0] po_a = `PW_OFS_POLARITY;
    localparam logic [1:0] ok_r = `PW_RESP_OKAY;
    localparam logic [1:0] err_r = `PW_RESP_SLVERR;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic shallow_stop_state = 1'b0;
    logic deep_stop_state = 1'b0;
    logic debug_active = 1'b0;
    logic [1:0] port_pull_enable = 2'b00;
    logic [1:0] drv_en = 2'b11;
    logic [1:0] drv_lvl = 2'b11;
    logic [1:0] wake_input_pin;
    logic [1:0] pull_up_enable;
    logic [1:0] pull_down_enable;
    logic irq_request;
    logic wake_request;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready;
    logic s_axi_wready;
    logic s_axi_bvalid;
    logic s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp;
    logic [1:0] s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int fail_count = 0;
    int comparisons = 0;

    pin_wake_interrupt_unit pin_wake_interrupt_unit_i (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .wake_input_pin(wake_input_pin),
        .port_pull_enable(port_pull_enable),
        .shallow_stop_state(shallow_stop_state),
        .deep_stop_state(deep_stop_state),
        .debug_active(debug_active),
        .pull_up_enable(pull_up_enable),
        .pull_down_enable(pull_down_enable),
        .irq_request(irq_request),
        .wake_request(wake_request),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    pin_source_model pin_source_model_i (
        .ref_clk(ref_clk),
        .drive_en(drv_en),
        .drive_level(drv_lvl),
        .pull_up_enable(pull_up_enable),
        .pull_down_enable(pull_down_enable),
        .pin(wake_input_pin)
    );

    always #5 ref_clk = ~ref_clk;

    task automatic test_done;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Each channel is looked at on the rising edge at which it moves
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
                done = 1'b1;
            end
        end
        if (!done) begin
            fail_count++;
            $display("BAD bresp expected %h seen timeout", er);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
                chk("rdata", ed, s_axi_rdata);
                done = 1'b1;
            end
        end
        if (!done) begin
            fail_count++;
            $display("BAD rdata expected %h seen timeout", ed);
        end
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rd(sc_a, 32'h0, ok_r);
        rd(en_a, 32'h0, ok_r);
        rd(po_a, 32'h0, ok_r);
        rd(8'h0c, 32'h0, err_r);
        wr(8'h10, 32'h1, err_r);
        wr(en_a, 32'h1a5, ok_r);
        rd(en_a, 32'ha5, ok_r);
        s_axi_wstrb <= 4'he;
        wr(en_a, 32'h0, ok_r);
        s_axi_wstrb <= 4'hf;
        rd(en_a, 32'ha5, ok_r);
        wr(sc_a, 32'hfc, ok_r);
        rd(sc_a, 32'h0, ok_r);
        wr(en_a, 32'h1, ok_r);
        wr(sc_a, 32'h6, ok_r);
        rd(sc_a, 32'h2, ok_r);
        drv_lvl <= 2'b10;
        tick(4);
        chk("irq", 32'h1, {31'h0, irq_request});
        rd(sc_a, 32'ha, ok_r);
        wr(sc_a, 32'h6, ok_r);
        rd(sc_a, 32'h2, ok_r);
        drv_lvl <= 2'b00;
        tick(4);
        rd(sc_a, 32'h2, ok_r);
        wr(po_a, 32'h3, ok_r);
        wr(sc_a, 32'h6, ok_r);
        clk_en <= 1'b0;
        drv_lvl <= 2'b11;
        tick(4);
        chk("irq", 32'h0, {31'h0, irq_request});
        clk_en <= 1'b1;
        tick(4);
        rd(sc_a, 32'ha, ok_r);
        wr(en_a, 32'h3, ok_r);
        wr(sc_a, 32'h6, ok_r);
        tick(4);
        rd(sc_a, 32'h2, ok_r);
        port_pull_enable <= 2'b11;
        tick(1);
        chk("pull_down", 32'h3, {30'h0, pull_down_enable});
        chk("pull_up", 32'h0, {30'h0, pull_up_enable});
        debug_active <= 1'b1;
        wr(sc_a, 32'h7, ok_r);
        rd(sc_a, 32'hb, ok_r);
        shallow_stop_state <= 1'b1;
        tick(1);
        chk("wake", 32'h1, {31'h0, wake_request});
        drv_en <= 2'b00;
        tick(1);
        chk("wake", 32'h0, {31'h0, wake_request});
        tick(4);
        shallow_stop_state <= 1'b0;
        wr(sc_a, 32'h7, ok_r);
        rd(sc_a, 32'h3, ok_r);
        wr(sc_a, 32'h1, ok_r);
        drv_en <= 2'b01;
        drv_lvl <= 2'b01;
        tick(4);
        chk("irq", 32'h0, {31'h0, irq_request});
        rd(sc_a, 32'h9, ok_r);
        wr(sc_a, 32'h5, ok_r);
        rd(sc_a, 32'h9, ok_r);
        wr(sc_a, 32'h3, ok_r);
        chk("irq", 32'h1, {31'h0, irq_request});
        wr(po_a, 32'h1, ok_r);
        chk("pull_up", 32'h2, {30'h0, pull_up_enable});
        chk("pull_down", 32'h1, {30'h0, pull_down_enable});
        deep_stop_state <= 1'b1;
        tick(2);
        deep_stop_state <= 1'b0;
        rd(sc_a, 32'h0, ok_r);
        rd(en_a, 32'h0, ok_r);
        rd(po_a, 32'h0, ok_r);
        chk("irq", 32'h0, {31'h0, irq_request});
        test_done();
    end
endmodule

`default_nettype wire
